//--- pkg/acd_defs.svh
`ifndef ACD_DEFS_SVH
`define ACD_DEFS_SVH
// frame and field layout of the serial word
`define ACD_WORD_BITS      16
`define ACD_CNT_W          5
`define ACD_CNT_ZERO       5'h00
`define ACD_CNT_LAST       5'h10
`define ACD_CNT_EDGE15     5'h0f
`define ACD_CNT_RISE14     5'h0e
`define ACD_WR_BIT         15
`define ACD_SEL_HI         14
`define ACD_SEL_LO         13
`define ACD_SEL_CTRL       2'h0
`define ACD_SEL_RANGE_LO   2'h1
`define ACD_SEL_RANGE_HI   2'h2
`define ACD_SEL_SEQ        2'h3
`define ACD_CTRL_MSB       12
`define ACD_CTRL_LSB       1
`define ACD_BYTE_MSB       12
`define ACD_BYTE_LSB       5
// control register fields, within the 12-bit register
`define ACD_CTRL_RESET     12'h000
`define ACD_F_ADDR_MSB     11
`define ACD_F_ADDR_LSB     9
`define ACD_F_MODE_MSB     8
`define ACD_F_MODE_LSB     7
`define ACD_F_PWR_MSB      6
`define ACD_F_PWR_LSB      5
`define ACD_F_CODING       4
`define ACD_F_REF          3
`define ACD_F_SEQA         2
`define ACD_F_SEQB         1
`define ACD_F_WEAK         0
// range and sequence defaults, temperature address and mux input codes
`define ACD_RANGE_RESET    8'h00
`define ACD_SEQ_RESET      8'h00
`define ACD_ADDR_TEMP      3'h7
`define ACD_NEG_VIN7       4'h7
`define ACD_NEG_GND        4'h8
`define ACD_NEG_TEMP       4'h9
`endif

//--- pkg/acd_pkg.sv
package acd_pkg;
  // input arrangement codes
  typedef enum logic [1:0] {
    ACD_MODE_SINGLE = 2'h0,
    ACD_MODE_PSEUDO4 = 2'h1,
    ACD_MODE_DIFF4 = 2'h2,
    ACD_MODE_PSEUDO7 = 2'h3
  } acd_mode_e;
  // power codes
  typedef enum logic [1:0] {
    ACD_PWR_NORMAL = 2'h0,
    ACD_PWR_STANDBY = 2'h1,
    ACD_PWR_AUTOSHUT = 2'h2,
    ACD_PWR_FULLSHUT = 2'h3
  } acd_pwr_e;
  // sequencer operation
  typedef enum logic [1:0] {
    ACD_SEQ_OFF = 2'h0,
    ACD_SEQ_PROG = 2'h1,
    ACD_SEQ_RUN = 2'h2
  } acd_seq_e;
  // frame receiver states, gray along idle-shift-done
  typedef enum logic [1:0] {
    ACD_ST_IDLE = 2'h0,
    ACD_ST_SHIFT = 2'h1,
    ACD_ST_DONE = 2'h3
  } acd_state_e;
endpackage

//--- core/acd_sync.sv
`timescale 1ns/1ps
// two-flop synchroniser for pin inputs
module acd_sync #(
  parameter int W = 1
) (
  // clock and reset
  input  wire logic         ref_clk,
  input  wire logic         sys_rst,
  // async in, sync out
  input  wire logic [W-1:0] din,
  output logic      [W-1:0] dout
);
  logic [W-1:0] meta;

  // first stage read only by second
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      meta <= '0;
      dout <= '0;
    end else begin
      meta <= din;
      dout <= meta;
    end
  end
endmodule

//--- core/acd_byte_regs.sv
`timescale 1ns/1ps
`include "acd_defs.svh"
// range and sequence registers, one write strobe each
module acd_byte_regs (
  // clock and reset
  input  wire logic       ref_clk,
  input  wire logic       sys_rst,
  // write side
  input  wire logic [2:0] wr_en,
  input  wire logic [7:0] wr_data,
  // held contents
  output logic      [7:0] range_lo,
  output logic      [7:0] range_hi,
  output logic      [7:0] seq_mask
);
  logic [7:0] regs [3];

  // one register per strobe
  for (genvar i = 0; i < 3; i++) begin : g_reg
    always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
        regs[i] <= `ACD_RANGE_RESET;
      end else if (wr_en[i]) begin
        regs[i] <= wr_data;
      end
    end
  end

  assign range_lo = regs[0];
  assign range_hi = regs[1];
  assign seq_mask = regs[2];
endmodule

//--- core/acd_reg_decoder.sv
`timescale 1ns/1ps
`include "acd_defs.svh"
// Behaviour
// - a frame is 16 serial clocks; first three bits are write flag and target select
// - write flag 0 leaves all registers unchanged and ignores the frame
// - write with select 00 loads the next 12 bits into control
// - write with select 01 loads 8 bits into range register for channels 0-3
// - write with select 10 loads 8 bits into range register for channels 4-7
// - write with select 11 loads 8 bits into the sequence register
// - control register is 12 bits, write-only, zero after power-up
// - control settings apply from the next conversion on
// - address bits pick next channel, or last channel of a sequencer run
// - mode bits choose single, four pseudo pairs, four diff pairs, seven pseudo
// - pair modes map address to even positive, odd negative, ignore address lsb
// - single uses ground as negative; seven pseudo uses input 7, address 7 is temperature
// - power 11 shuts everything down while keeping control contents
// - power 10 auto-shutdown begins on 15th rising edge of the updating frame
// - power 01 auto-standby keeps reference, begins on 15th rising edge
// - power 00 keeps everything powered
// - coding bit 0 two's complement, 1 straight binary, held for sequences
// - ref bit 1 internal reference, 0 external with internal disabled
// - sequencer flags in control bits 2 and 1 govern sequencing
// - weak bit 1 drives output weakly with next address top bit, else high-z
// - flags 00/11 off, 01 programmed sequence, 10 channel 0 up to address
// - two range bits per channel, 00 is the default range
// - sequence register holds one enable bit per channel, channel 0 first
module acd_reg_decoder (
  // clock and reset
  input  wire logic                 ref_clk,
  input  wire logic                 sys_rst,
  // serial pins
  input  wire logic                 sclk,
  input  wire logic                 cs_n,
  input  wire logic                 din,
  // conversion handshake from the converter core
  input  wire logic                 conv_start,
  // control register and decoded fields
  output logic [11:0]               conversion_control,
  output logic [2:0]                chan_addr,
  output logic                      chan_addr_top,
  output logic                      chan_addr_mid,
  output logic                      chan_addr_low,
  output acd_pkg::acd_mode_e        input_mode,
  output logic [3:0]                vin_pos,
  output logic [3:0]                vin_neg,
  output logic                      temp_sel,
  output logic                      power_sel_hi,
  output logic                      power_sel_lo,
  output acd_pkg::acd_pwr_e         power_mode,
  output logic                      power_down_all,
  output logic                      power_down_keep_ref,
  output logic                      coding_binary,
  output logic                      ref_internal,
  output logic                      sequencer_flag_a,
  output logic                      sequencer_flag_b,
  output acd_pkg::acd_seq_e         seq_op,
  output logic [2:0]                seq_last_chan,
  // range and sequence registers
  output logic [7:0]                range_lo,
  output logic [7:0]                range_hi,
  output logic [7:0]                seq_mask,
  // serial output idle control
  output logic                      dout_weak_o,
  output logic                      dout_weak_oe,
  // frame status
  output logic                      frame_done
);
  logic [2:0]               pins_s;
  logic                     sclk_s;
  logic                     cs_n_s;
  logic                     din_s;
  logic                     sclk_d;
  logic                     fall_edge;
  logic                     rise_edge;
  acd_pkg::acd_state_e      state;
  logic [`ACD_CNT_W-1:0]    bit_cnt;
  logic [`ACD_CNT_W-1:0]    rise_cnt;
  logic [15:0]              shreg;
  logic [15:0]              next_shreg;
  logic                     word_ok;
  logic                     wr_word;
  logic [1:0]               sel;
  logic [2:0]               byte_we;
  logic [11:0]              ctrl_pend;
  logic                     pend_valid;
  logic                     weak_en;
  logic                     ctrl_frame;
  logic                     pd_armed;
  acd_pkg::acd_pwr_e        pend_pwr;

  // pin synchronisation, clock and select carried inverted so reset reads idle high
  acd_sync #(
    .W (3)
  ) u_sync (
    .ref_clk (ref_clk),
    .sys_rst (sys_rst),
    .din     ({~sclk, ~cs_n, din}),
    .dout    (pins_s)
  );
  assign sclk_s = ~pins_s[2];
  assign cs_n_s = ~pins_s[1];
  assign din_s  = pins_s[0];

  // serial clock edge detection on synced copy
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      sclk_d <= 1'b1;
    end else begin
      sclk_d <= sclk_s;
    end
  end
  assign fall_edge = sclk_d & ~sclk_s;
  assign rise_edge = ~sclk_d & sclk_s;

  // shift msb first on falling edges
  assign next_shreg = {shreg[14:0], din_s};

  // frame receiver
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      state    <= acd_pkg::ACD_ST_IDLE;
      bit_cnt  <= `ACD_CNT_ZERO;
      rise_cnt <= `ACD_CNT_ZERO;
      shreg    <= 16'h0000;
    end else begin
      case (state)
        acd_pkg::ACD_ST_IDLE: begin
          bit_cnt  <= `ACD_CNT_ZERO;
          rise_cnt <= `ACD_CNT_ZERO;
          if (!cs_n_s) begin
            state <= acd_pkg::ACD_ST_SHIFT;
          end
        end
        acd_pkg::ACD_ST_SHIFT: begin
          if (cs_n_s) begin
            state <= acd_pkg::ACD_ST_IDLE; // short frame discarded
          end else begin
            if (rise_edge) begin
              rise_cnt <= rise_cnt + 5'h01;
            end
            if (fall_edge) begin
              shreg   <= next_shreg;
              bit_cnt <= bit_cnt + 5'h01;
              if (bit_cnt == `ACD_CNT_EDGE15) begin
                state <= acd_pkg::ACD_ST_DONE;
              end
            end
          end
        end
        acd_pkg::ACD_ST_DONE: begin
          if (cs_n_s) begin
            state <= acd_pkg::ACD_ST_IDLE;
          end
        end
        default: begin
          state <= acd_pkg::ACD_ST_IDLE;
        end
      endcase
    end
  end

  // decode of a completed word
  assign word_ok = (state == acd_pkg::ACD_ST_SHIFT) && !cs_n_s && fall_edge
                   && (bit_cnt == `ACD_CNT_EDGE15);
  assign wr_word = word_ok && next_shreg[`ACD_WR_BIT];
  assign sel     = {next_shreg[`ACD_SEL_HI], next_shreg[`ACD_SEL_LO]};
  assign byte_we = {wr_word && (sel == `ACD_SEL_SEQ),
                    wr_word && (sel == `ACD_SEL_RANGE_HI),
                    wr_word && (sel == `ACD_SEL_RANGE_LO)};
  assign frame_done = word_ok;

  // range and sequence storage
  acd_byte_regs u_bytes (
    .ref_clk  (ref_clk),
    .sys_rst  (sys_rst),
    .wr_en    (byte_we),
    .wr_data  (next_shreg[`ACD_BYTE_MSB:`ACD_BYTE_LSB]),
    .range_lo (range_lo),
    .range_hi (range_hi),
    .seq_mask (seq_mask)
  );

  // pending control word, applied when next conversion starts
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      ctrl_pend  <= `ACD_CTRL_RESET;
      pend_valid <= 1'b0;
    end else if (wr_word && (sel == `ACD_SEL_CTRL)) begin
      ctrl_pend  <= next_shreg[`ACD_CTRL_MSB:`ACD_CTRL_LSB];
      pend_valid <= 1'b1;
    end else if (conv_start) begin
      pend_valid <= 1'b0;
    end
  end

  // active control register
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      conversion_control <= `ACD_CTRL_RESET;
    end else if (conv_start && pend_valid) begin
      conversion_control <= ctrl_pend;
    end
  end

  // output idle state follows the last control write as soon as its frame ends
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      weak_en <= 1'b0;
    end else if (wr_word && (sel == `ACD_SEL_CTRL)) begin
      weak_en <= next_shreg[`ACD_CTRL_LSB + `ACD_F_WEAK];
    end
  end
  assign dout_weak_oe = weak_en && (state != acd_pkg::ACD_ST_SHIFT);
  assign dout_weak_o  = dout_weak_oe && ctrl_pend[`ACD_F_ADDR_MSB];

  // auto power-down timing on the 15th rising edge
  // after 15 falls the header sits one place below its word position
  assign ctrl_frame = (state == acd_pkg::ACD_ST_SHIFT) && !cs_n_s
                      && shreg[`ACD_WR_BIT - 1]
                      && ({shreg[`ACD_SEL_HI - 1], shreg[`ACD_SEL_LO - 1]} == `ACD_SEL_CTRL)
                      && (bit_cnt == `ACD_CNT_EDGE15);
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      pd_armed <= 1'b0;
      pend_pwr <= acd_pkg::ACD_PWR_NORMAL;
    end else if (ctrl_frame && rise_edge && (rise_cnt == `ACD_CNT_RISE14)) begin
      pd_armed <= 1'b1;
      pend_pwr <= acd_pkg::acd_pwr_e'(shreg[`ACD_F_PWR_MSB:`ACD_F_PWR_LSB]); // field index
    end else if (conv_start) begin
      pd_armed <= 1'b0;
    end
  end

  // field decode
  assign chan_addr     = conversion_control[`ACD_F_ADDR_MSB:`ACD_F_ADDR_LSB];
  assign chan_addr_top = chan_addr[2];
  assign chan_addr_mid = chan_addr[1];
  assign chan_addr_low = chan_addr[0];
  assign input_mode    = acd_pkg::acd_mode_e'(
                           conversion_control[`ACD_F_MODE_MSB:`ACD_F_MODE_LSB]);
  assign power_sel_hi  = conversion_control[`ACD_F_PWR_MSB];
  assign power_sel_lo  = conversion_control[`ACD_F_PWR_LSB];
  assign power_mode    = pd_armed ? pend_pwr
                         : acd_pkg::acd_pwr_e'({power_sel_hi, power_sel_lo});
  assign coding_binary = conversion_control[`ACD_F_CODING];
  assign ref_internal  = conversion_control[`ACD_F_REF];
  assign sequencer_flag_a = conversion_control[`ACD_F_SEQA];
  assign sequencer_flag_b = conversion_control[`ACD_F_SEQB];
  assign seq_last_chan = chan_addr;

  // power state: full shutdown keeps register contents
  always_comb begin
    power_down_all      = 1'b0;
    power_down_keep_ref = 1'b0;
    case (power_mode)
      acd_pkg::ACD_PWR_FULLSHUT: power_down_all = 1'b1;
      acd_pkg::ACD_PWR_AUTOSHUT: power_down_all = 1'b1;
      acd_pkg::ACD_PWR_STANDBY:  power_down_keep_ref = 1'b1;
      default:                   power_down_all = 1'b0;
    endcase
  end

  // sequencer operation
  always_comb begin
    case ({sequencer_flag_a, sequencer_flag_b})
      2'h1:    seq_op = acd_pkg::ACD_SEQ_PROG;
      2'h2:    seq_op = acd_pkg::ACD_SEQ_RUN;
      default: seq_op = acd_pkg::ACD_SEQ_OFF;
    endcase
  end

  // input mux mapping
  always_comb begin
    vin_pos  = {1'b0, chan_addr};
    vin_neg  = `ACD_NEG_GND;
    temp_sel = 1'b0;
    case (input_mode)
      acd_pkg::ACD_MODE_DIFF4, acd_pkg::ACD_MODE_PSEUDO4: begin
        vin_pos = {1'b0, chan_addr[2:1], 1'b0};
        vin_neg = {1'b0, chan_addr[2:1], 1'b1};
      end
      acd_pkg::ACD_MODE_PSEUDO7: begin
        vin_neg = `ACD_NEG_VIN7;
        if (chan_addr == `ACD_ADDR_TEMP) begin
          temp_sel = 1'b1;
          vin_pos  = `ACD_NEG_TEMP;
        end
      end
      default: begin
        vin_neg = `ACD_NEG_GND;
      end
    endcase
  end
endmodule

//--- verification/acd_host_model.sv
`timescale 1ns/1ps
// host end of the serial write link, sclk idles high
module acd_host_model (
  // serial pins
  output logic sclk,
  output logic cs_n,
  output logic din
);
  // pins idle between frames
  initial begin
    sclk = 1'b1;
    cs_n = 1'b1;
    din  = 1'b0;
  end
  // one frame msb first, a short count aborts it
  task automatic send(input logic [15:0] w, input int nbits);
    #13 cs_n = 1'b0;
    for (int i = 15; i > 15 - nbits; i--) begin
      din = w[i];
      #80 sclk = 1'b0;
      #80 sclk = 1'b1;
    end
    #80 cs_n = 1'b1;
    din = ~din; // released line keeps no stale level
  endtask
endmodule

//--- verification/acd_reg_decoder_asserts.sv
`timescale 1ns/1ps
// port-level checks of the decoder
module acd_reg_decoder_asserts (
  // clock and reset
  input wire logic               ref_clk,
  input wire logic               sys_rst,
  // handshake and status
  input wire logic               conv_start,
  input wire logic               frame_done,
  // control register and decoded fields
  input wire logic [11:0]        conversion_control,
  input wire logic [2:0]         chan_addr,
  input wire logic               chan_addr_top,
  input wire logic               chan_addr_mid,
  input wire logic               chan_addr_low,
  input wire logic [2:0]         seq_last_chan,
  input wire acd_pkg::acd_mode_e input_mode,
  input wire logic [3:0]         vin_pos,
  input wire logic [3:0]         vin_neg,
  input wire logic               temp_sel,
  input wire acd_pkg::acd_pwr_e  power_mode,
  input wire logic               power_down_all,
  input wire logic               power_down_keep_ref,
  input wire logic               power_sel_hi,
  input wire logic               power_sel_lo,
  input wire logic               coding_binary,
  input wire logic               ref_internal,
  input wire logic               sequencer_flag_a,
  input wire logic               sequencer_flag_b,
  input wire acd_pkg::acd_seq_e  seq_op
);
  default clocking @(posedge ref_clk);
  endclocking
  default disable iff (sys_rst);
  // register and field relations, plus frame done spacing
  a_ctrl_deferred: assert property ($changed(conversion_control) |-> $past(conv_start))
    else $error("control changed without conversion start");
  a_done_spacing: assert property (frame_done |=> !frame_done [*8])
    else $error("frame done pulses too close");
  a_addr_field: assert property (chan_addr == conversion_control[11:9]
    && seq_last_chan == chan_addr) else $error("address field wrong");
  a_field_bits: assert property ({chan_addr_top, chan_addr_mid, chan_addr_low} ==
    conversion_control[11:9] && {power_sel_hi, power_sel_lo} == conversion_control[6:5])
    else $error("address or power bits wrong");
  a_mode_field: assert property (input_mode == conversion_control[8:7])
    else $error("mode field wrong");
  a_pair_map: assert property (input_mode[1] != input_mode[0] |->
    vin_pos == {1'b0, chan_addr[2:1], 1'b0} && vin_neg == vin_pos + 4'h1)
    else $error("pair mapping wrong");
  a_single_gnd: assert property (input_mode == acd_pkg::ACD_MODE_SINGLE |->
    vin_pos == {1'b0, chan_addr} && vin_neg == 4'h8) else $error("single mapping wrong");
  a_temp_pick: assert property (temp_sel == (input_mode == acd_pkg::ACD_MODE_PSEUDO7
    && chan_addr == 3'h7)) else $error("temperature pick wrong");
  a_power_flags: assert property (power_down_all == power_mode[1]
    && power_down_keep_ref == (power_mode == acd_pkg::ACD_PWR_STANDBY))
    else $error("power flags wrong");
  a_coding_ref: assert property (coding_binary == conversion_control[4]
    && ref_internal == conversion_control[3]) else $error("coding or reference wrong");
  a_seq_decode: assert property ({sequencer_flag_a, sequencer_flag_b} ==
    conversion_control[2:1] && seq_op == (sequencer_flag_a == sequencer_flag_b ?
    acd_pkg::ACD_SEQ_OFF : sequencer_flag_a ? acd_pkg::ACD_SEQ_RUN : acd_pkg::ACD_SEQ_PROG))
    else $error("sequencer decode wrong");
  // main scenarios reached
  c_frame: cover property (frame_done);
  c_temp: cover property (temp_sel);
  c_standby: cover property (power_down_keep_ref);
  c_autoshut: cover property (power_mode == acd_pkg::ACD_PWR_AUTOSHUT);
endmodule

bind acd_reg_decoder acd_reg_decoder_asserts u_asserts (
  .ref_clk, .sys_rst, .conv_start, .frame_done, .conversion_control, .chan_addr,
  .seq_last_chan, .input_mode, .vin_pos, .vin_neg, .temp_sel, .power_mode,
  .power_down_all, .power_down_keep_ref, .coding_binary, .ref_internal,
  .sequencer_flag_a, .sequencer_flag_b, .seq_op, .chan_addr_top, .chan_addr_mid,
  .chan_addr_low, .power_sel_hi, .power_sel_lo
);

//--- verification/test_acd_reg_decoder.sv
`timescale 1ns/1ps
// self-checking bench for the serial register decoder
module test_acd_reg_decoder;
  // one write and the register contents it should leave
  typedef struct packed {
    logic [15:0] w;
    logic [7:0]  rl;
    logic [7:0]  rh;
    logic [7:0]  sm;
    logic [11:0] cc;
  } acd_row_s;
  logic               ref_clk, sys_rst, conv_start, sclk, cs_n, din;
  logic               temp_sel, power_down_all, power_down_keep_ref, coding_binary;
  logic               ref_internal, dout_weak_o, dout_weak_oe, frame_done;
  logic [11:0]        conversion_control, c;
  logic [2:0]         chan_addr;
  logic [3:0]         vin_pos, vin_neg;
  logic [7:0]         range_lo, range_hi, seq_mask;
  acd_pkg::acd_mode_e input_mode;
  acd_pkg::acd_pwr_e  power_mode;
  acd_pkg::acd_seq_e  seq_op;
  int                 fails, checked, seen;
  int                 ndone = 0;
  // writes to ranges and sequence before control, plus two frames with write flag 0
  acd_row_s rows [7] = '{
    '{{3'b101, 8'ha5, 5'h00}, 8'ha5, 8'h00, 8'h00, 12'h000},
    '{{3'b110, 8'h3c, 5'h00}, 8'ha5, 8'h3c, 8'h00, 12'h000},
    '{{3'b111, 8'h81, 5'h00}, 8'ha5, 8'h3c, 8'h81, 12'h000},
    '{{3'b011, 8'hff, 5'h00}, 8'ha5, 8'h3c, 8'h81, 12'h000},
    '{{3'b100, 12'hfff, 1'b1}, 8'ha5, 8'h3c, 8'h81, 12'hfff},
    '{{3'b100, 12'h2b4, 1'b0}, 8'ha5, 8'h3c, 8'h81, 12'h2b4},
    '{{3'b000, 13'h1fff}, 8'ha5, 8'h3c, 8'h81, 12'h2b4}
  };
  acd_host_model host (.sclk, .cs_n, .din);
  acd_reg_decoder dut (
    .ref_clk, .sys_rst, .sclk, .cs_n, .din, .conv_start, .conversion_control, .chan_addr,
    .chan_addr_top(), .chan_addr_mid(), .chan_addr_low(), .input_mode, .vin_pos, .vin_neg,
    .temp_sel, .power_sel_hi(), .power_sel_lo(), .power_mode, .power_down_all,
    .power_down_keep_ref, .coding_binary, .ref_internal, .sequencer_flag_a(),
    .sequencer_flag_b(), .seq_op, .seq_last_chan(), .range_lo, .range_hi, .seq_mask,
    .dout_weak_o, .dout_weak_oe, .frame_done
  );
  // clock
  initial begin
    ref_clk = 1'b0;
    forever #10 ref_clk = ~ref_clk;
  end
  // count completed frames
  always @(posedge ref_clk) if (frame_done === 1'b1) ndone <= ndone + 1;
  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
  endtask
  task automatic chk(input logic [11:0] got, input logic [11:0] exp, input string what);
    checked++;
    if (got !== exp) begin
      fails++;
      $display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask
  task automatic results();
    if (fails == 0 && checked > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  // full frame, bounded wait for done, then the register load
  task automatic frame(input logic [15:0] w);
    seen = ndone;
    host.send(w, 16);
    for (int i = 0; i < 400 && ndone == seen; i++) @(posedge ref_clk);
    if (ndone == seen) begin
      fails++;
      $display("Error at %0t: no frame done", $time);
      results();
    end
    tick(2);
  endtask
  task automatic start_conv();
    conv_start <= 1'b1;
    @(posedge ref_clk);
    conv_start <= 1'b0;
    tick(2);
  endtask
  // watchdog
  initial begin
    tick(100000);
    fails++;
    $display("Error at %0t: timeout", $time);
    results();
  end
  // main sequence
  initial begin
    sys_rst = 1'b1;
    conv_start = 1'b0;
    fails = 0;
    checked = 0;
    tick(3);
    sys_rst <= 1'b0;
    tick(3);
    chk(conversion_control, 12'h000, "control reset");
    chk(vin_neg, 4'h8, "ground at reset");
    c = 12'h000;
    foreach (rows[i]) begin
      frame(rows[i].w);
      chk(range_lo, rows[i].rl, "range lo");
      chk(range_hi, rows[i].rh, "range hi");
      chk(seq_mask, rows[i].sm, "sequence");
      chk(conversion_control, c, "control before start");
      start_conv();
      chk(conversion_control, rows[i].cc, "control");
      c = rows[i].cc;
    end
    // every input arrangement at every address
    for (int m = 0; m < 4; m++) begin
      for (int a = 0; a < 8; a++) begin
        frame({3'b100, a[2:0], m[1:0], 7'h00, 1'b0});
        start_conv();
        chk(chan_addr, a[2:0], "address");
        chk(temp_sel, m == 3 && a == 7, "temperature");
        if (m == 0) begin
          chk({vin_pos, vin_neg}, {1'b0, a[2:0], 4'h8}, "single mux");
        end else if (m < 3) begin
          chk({vin_pos, vin_neg}, {1'b0, a[2:1], 2'h0, a[2:1], 1'b1}, "pair mux");
        end else if (a < 7) begin
          chk({vin_pos, vin_neg}, {1'b0, a[2:0], 4'h7}, "pseudo mux");
        end
      end
    end
    // every power code and sequencer flag pair, weak drive on
    for (int p = 0; p < 4; p++) begin
      c = {3'h4, 2'h0, p[1:0], p[0], p[1], p[1:0], 1'b1};
      frame({3'b100, c, 1'b0});
      chk(power_mode, p[1:0], "power code");
      chk(power_down_all, p[1], "all down");
      chk(power_down_keep_ref, p == 1, "standby");
      chk({dout_weak_oe, dout_weak_o}, 2'h3, "weak drive");
      start_conv();
      chk(conversion_control, c, "control kept");
      chk({coding_binary, ref_internal}, {p[0], p[1]}, "coding and ref");
      chk(seq_op, p == 1 ? 2'h1 : p == 2 ? 2'h2 : 2'h0, "sequencer");
    end
    frame({3'b100, 12'h000, 1'b0});
    chk(dout_weak_oe, 1'b0, "weak off");
    // frame cut short after ten bits
    seen = ndone;
    host.send({3'b101, 8'h00, 5'h00}, 10);
    tick(30);
    chk(ndone - seen, 12'h000, "short frame done");
    chk(range_lo, 8'ha5, "short frame write");
    // reset in mid-run
    sys_rst <= 1'b1;
    tick(3);
    sys_rst <= 1'b0;
    tick(3);
    chk(conversion_control, 12'h000, "control after reset");
    chk(range_hi, 8'h00, "range after reset");
    chk(seq_mask, 8'h00, "sequence after reset");
    results();
  end
endmodule
